// ---- hw/batb_pkg.sv ----
// Package: register map, field layouts and constants for the bank-aware trace/breakpoint block
package batb_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] STATUS_OFS   = 8'h04;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h08;
  localparam logic [7:0] QUAL_OFS     = 8'h0c;
  localparam logic [7:0] TRACE_OFS    = 8'h10;
  localparam logic [7:0] BRK_ADDR_OFS = 8'h14;
  localparam logic [7:0] BPMEM_OFS    = 8'h18;
  localparam logic [7:0] CMD_OFS      = 8'h1c;
  localparam logic [7:0] HALT_PC_OFS  = 8'h20;
  localparam logic [7:0] BRK_REG0_OFS = 8'h40;
  // Control fields
  localparam int CTRL_BANK_EN   = 0;
  localparam int CTRL_QUAL_EN   = 1;
  localparam int CTRL_VARIANT   = 2;
  localparam int CTRL_MODE_LO   = 3;
  localparam int CTRL_MODE_HI   = 4;
  localparam int CTRL_RUN_BPMEM = 5;
  // Qualifier fields
  localparam int QUAL_BANK_LO   = 16;
  localparam int QUAL_ROOT      = 18;
  // Command bits
  localparam int CMD_SET_ALL    = 0;
  localparam int CMD_CLR_RANGE  = 1;
  localparam int CMD_START_RUN  = 2;
  localparam int CMD_RESUME     = 3;
  // Status bits
  localparam int ST_QUAL_HALT   = 0;
  localparam int ST_BPMEM_HALT  = 1;
  localparam int ST_TRACE_REC   = 2;
  localparam int ST_BUSY        = 3;
  localparam int ST_EVENTS      = 3;
  // Reset values and other constants
  localparam logic [5:0]  CTRL_RST  = 6'h00;
  localparam logic [18:0] QUAL_RST  = 19'h40000;
  localparam logic [15:0] BANK_AREA_START = 16'h8000;
  localparam logic [1:0]  MODE_XDATA = 2'h3;
  localparam logic [1:0]  MODE_BIG_BANK = 2'h2;
  localparam int NUM_BRK_REGS = 4;
  localparam int CODE_SPACE_BITS = 16;
  localparam int MEM_WORD_BITS = 32;
endpackage

// ---- hw/batb_bpmem_if.sv ----
// Interface: breakpoint memory port between the top and the memory module
`timescale 1ns/10ps
interface batb_bpmem_if;
  logic        fill;
  logic [15:0] fill_addr;
  logic        fill_val;
  logic        wr;
  logic [15:0] wr_addr;
  logic        wr_val;
  logic [15:0] rd_addr;
  logic        rd_bit;
  logic        rd_valid;
  modport ctrl (output fill, fill_addr, fill_val, wr, wr_addr, wr_val, rd_addr, input rd_bit, rd_valid);
  modport mem  (input fill, fill_addr, fill_val, wr, wr_addr, wr_val, rd_addr, output rd_bit, rd_valid);
endinterface

// ---- hw/batb_bpmem.sv ----
// Module: one breakpoint bit per code address, word-organised for fast fill
`timescale 1ns/10ps
module batb_bpmem #(
  parameter int ADDR_W = 16
) (
  // Clock
  input wire logic core_clk,
  // Memory port
  batb_bpmem_if.mem bp
);
  localparam int WORDS = (1 << ADDR_W) / 32;
  localparam int WA_W  = ADDR_W - 5;

  logic [31:0] mem_q [WORDS];
  logic        rd_valid_q;
  logic        rd_bit_q;

  // Fill writes a whole word per clock, so set-all and the start-run wipe take 2048 cycles
  always_ff @(posedge core_clk) begin
    if (bp.fill) begin
      mem_q[bp.fill_addr[ADDR_W-1:5]] <= {32{bp.fill_val}};
    end else if (bp.wr) begin
      mem_q[bp.wr_addr[ADDR_W-1:5]][bp.wr_addr[4:0]] <= bp.wr_val;
    end
  end

  always_ff @(posedge core_clk) begin
    rd_bit_q   <= mem_q[bp.rd_addr[ADDR_W-1:5]][bp.rd_addr[4:0]];
    rd_valid_q <= 1'b1;
  end

  assign bp.rd_bit   = rd_bit_q;
  assign bp.rd_valid = rd_valid_q;
endmodule

// ---- hw/batb_probe_sync.sv ----
// Module: two-flop synchroniser for the bank probe pins and bus-cycle strobe
`timescale 1ns/10ps
module batb_probe_sync #(
  parameter int W = 4
) (
  // Clock
  input  wire logic         core_clk,
  // Pins
  input  wire logic [W-1:0] pin_in,
  // Synchronised
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge core_clk) begin
    meta_q <= pin_in;
    sync_q <= meta_q;
  end

  assign sync_out = sync_q;
endmodule

// ---- hw/batb_top.sv ----
// Our own choices: the address map and register access over APB.
`timescale 1ns/10ps
module batb_top #(
  parameter int NUM_BRK = batb_pkg::NUM_BRK_REGS
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Emulated bus, from pod pins
  input  wire logic        bank_probe_low,
  input  wire logic        bank_probe_low_conn,
  input  wire logic        bank_probe_high,
  input  wire logic        bank_probe_high_conn,
  input  wire logic        fetch_strobe,
  input  wire logic [15:0] fetch_addr,
  input  wire logic [5:0]  probe_port_field,
  // Emulation control
  output logic             halt_req,
  output logic             xdata_emul_en,
  output logic [2:0]       bank_size_sel,
  output logic             irq
);
  typedef enum logic [1:0] {IDLE, FILL, LOAD} batb_fill_e;

  logic [4:0]  pin_sync;
  logic        probe_lo, probe_hi, conn_lo, conn_hi, strobe_s, strobe_d1_q;
  logic [15:0] addr_meta_q, addr_s_q;
  logic [5:0]  field_meta_q, field_s_q;
  batb_bpmem_if bp ();

  // Connection straps are pins as well, so they ride through the same two flops
  batb_probe_sync #(.W(5)) u_sync (
    .core_clk (core_clk),
    .pin_in   ({bank_probe_high_conn, bank_probe_low_conn, fetch_strobe, bank_probe_high, bank_probe_low}),
    .sync_out (pin_sync)
  );
  batb_bpmem #(.ADDR_W(batb_pkg::CODE_SPACE_BITS)) u_mem (
    .core_clk (core_clk),
    .bp       (bp.mem)
  );

  // Address and port field move with the strobe; two stages keep them aligned
  always_ff @(posedge core_clk) begin
    addr_meta_q  <= fetch_addr;
    addr_s_q     <= addr_meta_q;
    field_meta_q <= probe_port_field;
    field_s_q    <= field_meta_q;
    strobe_d1_q  <= pin_sync[2];
  end
  assign conn_lo  = pin_sync[3];
  assign conn_hi  = pin_sync[4];
  // Pod pull-ups make a floating probe read one
  assign probe_lo = conn_lo ? pin_sync[0] : 1'b1;
  assign probe_hi = conn_hi ? pin_sync[1] : 1'b1;
  // Rising edge only; a strobe held high must not record twice
  assign strobe_s = pin_sync[2] & ~strobe_d1_q;

  // Registers
  logic [5:0]  ctrl_q;
  logic [18:0] qual_q;
  logic [15:0] brk_q [NUM_BRK];
  logic [15:0] range_q;
  logic [2:0]  status_q, mask_q;
  logic [31:0] trace_q;
  logic [15:0] halt_pc_q;
  logic        halt_q;
  batb_fill_e  fstate_q;
  logic [15:0] fptr_q;
  logic        fval_q;
  logic        wr_acc, rd_acc, pready_q;
  logic [31:0] prdata_q;
  logic        ev_qual, ev_bpmem, ev_trace;
  logic [1:0]  bank_now;
  logic        cmd_wr;

  // Index width of the breakpoint address registers
  localparam int BRK_IW = $clog2(NUM_BRK);

  // Breakpoint register window, shared by the write and read decode
  function automatic logic in_brk_window(input logic [7:0] a);
    return a >= batb_pkg::BRK_REG0_OFS && a < batb_pkg::BRK_REG0_OFS + 8'(4 * NUM_BRK);
  endfunction

  assign wr_acc = psel & penable & pwrite & ~pready_q;
  assign rd_acc = psel & penable & ~pwrite & ~pready_q;
  assign cmd_wr = wr_acc && paddr == batb_pkg::CMD_OFS;
  assign bank_now = {probe_hi, probe_lo};

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_q  <= batb_pkg::CTRL_RST;
      qual_q  <= batb_pkg::QUAL_RST;
      mask_q  <= 3'h0;
      range_q <= 16'h0000;
    end else if (wr_acc) begin
      case (paddr)
        batb_pkg::CTRL_OFS:     ctrl_q <= pwdata[5:0];
        batb_pkg::QUAL_OFS:     qual_q <= pwdata[18:0];
        batb_pkg::IRQ_MASK_OFS: mask_q <= pwdata[2:0];
        // Range register names the single bit that a clear command drops
        batb_pkg::BPMEM_OFS:    range_q <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int i = 0; i < NUM_BRK; i++) brk_q[i] <= 16'h0000;
    end else if (wr_acc && in_brk_window(paddr)) begin
      brk_q[paddr[BRK_IW+1:2]] <= pwdata[15:0];
    end
  end

  // Variant decode: 128k has no external data, 256k only in mode 3
  // 128k builds ignore the mode field entirely
  always_ff @(posedge core_clk) begin
    if (srst) begin
      xdata_emul_en <= 1'b0;
      bank_size_sel <= 3'h0;
    end else begin
      xdata_emul_en <= ctrl_q[batb_pkg::CTRL_VARIANT] &&
                       ctrl_q[batb_pkg::CTRL_MODE_HI:batb_pkg::CTRL_MODE_LO] == batb_pkg::MODE_XDATA;
      // Code 1 selects 32k banks, 2 selects 64k banks; total mapped is 128k with code 1 and 256k with code 2
      bank_size_sel <= (ctrl_q[batb_pkg::CTRL_VARIANT] &&
                        ctrl_q[batb_pkg::CTRL_MODE_HI:batb_pkg::CTRL_MODE_LO] == batb_pkg::MODE_BIG_BANK)
                       ? 3'h2 : 3'h1;
    end
  end

  // Trace record: address and bank caught on the same strobe
  always_ff @(posedge core_clk) begin
    if (srst) begin
      trace_q <= 32'h0;
    end else if (strobe_s && ctrl_q[batb_pkg::CTRL_BANK_EN]) begin
      trace_q <= {8'h00, bank_now, field_s_q, addr_s_q};
    end
  end
  assign ev_trace = strobe_s & ctrl_q[batb_pkg::CTRL_BANK_EN];

  // Qualifier: bits 17:16 carry the bank, matched against the probe pins; the port field is ignored
  // Root bit lets one qualifier catch an address in any bank
  always_comb begin
    ev_qual = 1'b0;
    if (strobe_s && ctrl_q[batb_pkg::CTRL_QUAL_EN] && addr_s_q == qual_q[15:0]) begin
      if (addr_s_q < batb_pkg::BANK_AREA_START || qual_q[batb_pkg::QUAL_ROOT])
        ev_qual = 1'b1;
      else
        ev_qual = bank_now == qual_q[17:16];
    end
  end

  // Breakpoint memory read is one cycle late; fetch address held in addr_s_q
  logic chk_q;
  always_ff @(posedge core_clk) begin
    if (srst) chk_q <= 1'b0;
    else      chk_q <= strobe_s;
  end
  // Bit memory holds only addresses, so a bank mismatch can still halt here
  // Lookups are ignored while a fill is rewriting the bits under them
  assign ev_bpmem = chk_q & bp.rd_valid & ctrl_q[batb_pkg::CTRL_RUN_BPMEM] & bp.rd_bit
                    & (fstate_q == IDLE);

  // Fill engine: set-all, range clear, and run start
  // Start-run wipes every bit first so stale breaks cannot survive a reload
  always_ff @(posedge core_clk) begin
    if (srst) begin
      fstate_q <= IDLE;
      fptr_q   <= 16'h0000;
      fval_q   <= 1'b0;
    end else begin
      case (fstate_q)
        IDLE: begin
          if (cmd_wr) begin
            if (pwdata[batb_pkg::CMD_SET_ALL]) begin
              fstate_q <= FILL;
              fval_q   <= 1'b1;
              fptr_q   <= 16'h0000;
            end else if (pwdata[batb_pkg::CMD_START_RUN]) begin
              fstate_q <= FILL;
              fval_q   <= 1'b0;
              fptr_q   <= 16'h0000;
            end else if (pwdata[batb_pkg::CMD_CLR_RANGE]) begin
              fstate_q <= LOAD;
              fval_q   <= 1'b0;
              fptr_q   <= range_q;
            end
          end
        end
        FILL: begin
          fptr_q <= fptr_q + 16'h0020;
          if (fptr_q[15:5] == 11'h7ff) begin
            fstate_q <= fval_q ? IDLE : LOAD;
            fptr_q   <= 16'h0000;
            fval_q   <= 1'b1;
          end
        end
        LOAD: begin
          // Range clear writes a single bit; reload walks the address registers
          if (!fval_q || fptr_q == 16'(NUM_BRK - 1)) fstate_q <= IDLE;
          fptr_q <= fptr_q + 16'h0001;
        end
        default: fstate_q <= IDLE;
      endcase
    end
  end

  assign bp.fill      = fstate_q == FILL;
  assign bp.fill_addr = fptr_q;
  assign bp.fill_val  = fval_q;
  assign bp.wr        = fstate_q == LOAD;
  assign bp.wr_addr   = fval_q ? brk_q[fptr_q[BRK_IW-1:0]] : fptr_q;
  assign bp.wr_val    = fval_q;
  assign bp.rd_addr   = addr_s_q;

  // Halt holds until software resumes
  // A break in the resume cycle wins, so no halt is lost
  always_ff @(posedge core_clk) begin
    if (srst) begin
      halt_q    <= 1'b0;
      halt_pc_q <= 16'h0000;
    end else if (ev_qual || ev_bpmem) begin
      halt_q    <= 1'b1;
      halt_pc_q <= addr_s_q;
    end else if (cmd_wr && pwdata[batb_pkg::CMD_RESUME]) begin
      halt_q <= 1'b0;
    end
  end

  // Sticky status: set wins over a write-one clear
  always_ff @(posedge core_clk) begin
    if (srst) begin
      status_q <= 3'h0;
    end else begin
      for (int i = 0; i < batb_pkg::ST_EVENTS; i++) begin
        if (wr_acc && paddr == batb_pkg::STATUS_OFS && pwdata[i]) status_q[i] <= 1'b0;
      end
      if (ev_qual)  status_q[batb_pkg::ST_QUAL_HALT]  <= 1'b1;
      if (ev_bpmem) status_q[batb_pkg::ST_BPMEM_HALT] <= 1'b1;
      if (ev_trace) status_q[batb_pkg::ST_TRACE_REC]  <= 1'b1;
    end
  end

  // Registered so the pin never glitches while status and mask settle
  always_ff @(posedge core_clk) begin
    if (srst) irq <= 1'b0;
    else      irq <= |(status_q & mask_q);
  end

  // APB: one wait state, every access answers; unmapped reads zero
  // Writes land on the first access edge; pready rises on that same edge
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= psel & penable & ~pready_q;
      if (rd_acc) begin
        case (paddr)
          batb_pkg::CTRL_OFS:     prdata_q <= {26'h0, ctrl_q};
          batb_pkg::STATUS_OFS:   prdata_q <= {28'h0, fstate_q != IDLE, status_q};
          batb_pkg::IRQ_MASK_OFS: prdata_q <= {29'h0, mask_q};
          batb_pkg::QUAL_OFS:     prdata_q <= {13'h0, qual_q};
          batb_pkg::TRACE_OFS:    prdata_q <= trace_q;
          batb_pkg::BPMEM_OFS:    prdata_q <= {16'h0, range_q};
          batb_pkg::HALT_PC_OFS:  prdata_q <= {15'h0, halt_q, halt_pc_q};
          default: prdata_q <= in_brk_window(paddr) ? {16'h0, brk_q[paddr[BRK_IW+1:2]]} : 32'h0;
        endcase
      end
    end
  end

  assign prdata   = prdata_q;
  assign pready   = pready_q;
  assign pslverr  = 1'b0;
  assign halt_req = halt_q;
endmodule

// ---- tb/batb_top_sva.sv ----
// Checker: APB answer, halt and mode relations at the top ports, with covers for halt, interrupt and data emulation
`timescale 1ns/10ps
module batb_top_sva #(
  parameter int NUM_BRK = 4
) (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        srst,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Emulated bus and control
  input wire logic        fetch_strobe,
  input wire logic        halt_req,
  input wire logic        xdata_emul_en,
  input wire logic [2:0]  bank_size_sel,
  input wire logic        irq
);
  logic       stb_q;
  logic [3:0] age_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  always_ff @(posedge core_clk) stb_q <= fetch_strobe;
  // Cycles since the strobe rose; saturates so idle time cannot wrap
  always_ff @(posedge core_clk) begin
    if (srst) age_q <= 4'hf;
    else if (fetch_strobe && !stb_q) age_q <= 4'h0;
    else if (age_q != 4'hf) age_q <= age_q + 4'h1;
  end
  ready_one_cycle_a:
    assert property (pready |=> !pready) else $error("pready longer than one cycle");
  ready_wait_a:
    assert property (psel && $rose(penable) |=> pready) else $error("no answer after one wait state");
  ready_access_a:
    assert property (pready |-> psel && penable) else $error("pready outside access phase");
  no_error_a:
    assert property (!pslverr) else $error("pslverr raised");
  halt_release_a:
    assert property ($fell(halt_req) |-> $past(psel && pwrite && paddr == batb_pkg::CMD_OFS
      && pwdata[batb_pkg::CMD_RESUME])) else $error("halt dropped without resume");
  halt_cause_a:
    assert property ($rose(halt_req) |-> age_q < 4'ha) else $error("halt without recent fetch");
  xdata_size_a:
    assert property (xdata_emul_en |-> bank_size_sel == 3'h1) else $error("data emulation with wrong bank size");
  size_legal_a:
    assert property (!$past(srst) |-> bank_size_sel inside {3'h1, 3'h2}) else $error("illegal bank size");
  halt_seen_c: cover property ($rose(halt_req));
  irq_seen_c: cover property ($rose(irq));
  xdata_seen_c: cover property (xdata_emul_en);
endmodule
bind batb_top batb_top_sva #(.NUM_BRK(NUM_BRK)) chk (.core_clk(core_clk), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .fetch_strobe(fetch_strobe), .halt_req(halt_req), .xdata_emul_en(xdata_emul_en),
  .bank_size_sel(bank_size_sel), .irq(irq));

// ---- tb/batb_target_model.sv ----
// Partner: target bank-select wiring and code fetch cycles at the pod
`timescale 1ns/10ps
module batb_target_model (
  // Clock
  input wire logic    core_clk,
  // Pod pins
  output logic        lo,
  output logic        lo_conn,
  output logic        hi,
  output logic        hi_conn,
  output logic        strobe,
  output logic [15:0] addr,
  output logic [5:0]  field
);
  initial begin
    lo = 1'b0;
    hi = 1'b0;
    lo_conn = 1'b1;
    hi_conn = 1'b1;
    strobe = 1'b0;
    addr = 16'h0;
    field = 6'h0;
  end
  // Strap changes come through here so the pins keep a single driver
  task automatic set_conn(input logic l, input logic h);
    lo_conn <= l;
    hi_conn <= h;
  endtask
  // An unwired probe shows the inverse, so a stale value cannot pass
  task automatic fetch(input logic [15:0] a, input logic [1:0] b, input logic [5:0] f);
    @(posedge core_clk);
    lo <= lo_conn ? b[0] : ~b[0];
    hi <= hi_conn ? b[1] : ~b[1];
    addr <= a;
    field <= f;
    @(posedge core_clk);
    strobe <= 1'b1;
    repeat (4) @(posedge core_clk);
    strobe <= 1'b0;
    repeat (3) @(posedge core_clk);
    addr <= ~a;
    field <= ~f;
  endtask
endmodule

// ---- tb/tb.sv ----
// Testbench: register access, bank trace, qualified and memory breaks
`timescale 1ns/10ps
module tb;
  logic        core_clk, srst, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, halt_req, xdata_emul_en, irq;
  logic [2:0]  bank_size_sel;
  logic        b_lo, b_hi, c_lo, c_hi, stb;
  logic [15:0] f_addr;
  logic [5:0]  f_port;
  int          failures, compares;
  // Qualifier, fetch address, bank, halt expected
  logic [50:0] qt [5] = '{{32'h29000, 16'h9000, 2'h1, 1'b0}, {32'h29000, 16'h9000, 2'h2, 1'b1},
    {32'h21000, 16'h1000, 2'h0, 1'b1}, {32'h49000, 16'h9000, 2'h3, 1'b1}, {32'h39000, 16'h9004, 2'h3, 1'b0}};
  batb_top uut (.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bank_probe_low(b_lo), .bank_probe_low_conn(c_lo), .bank_probe_high(b_hi), .bank_probe_high_conn(c_hi),
    .fetch_strobe(stb), .fetch_addr(f_addr), .probe_port_field(f_port), .halt_req(halt_req),
    .xdata_emul_en(xdata_emul_en), .bank_size_sel(bank_size_sel), .irq(irq));
  batb_target_model tgt (.core_clk(core_clk), .lo(b_lo), .lo_conn(c_lo), .hi(b_hi), .hi_conn(c_hi),
    .strobe(stb), .addr(f_addr), .field(f_port));
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    check({31'h0, pready}, 32'h1, "pready");
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string m);
    xfer(1'b0, a, 32'h0);
    check(rd, e, m);
  endtask
  task automatic idle;
    int n;
    n = 0;
    do begin
      xfer(1'b0, batb_pkg::STATUS_OFS, 32'h0);
      n++;
    end while (rd[batb_pkg::ST_BUSY] !== 1'b0 && n < 2000);
    check(rd & 32'h8, 32'h0, "busy");
  endtask
  // Fetch, then check halt; a halt is resumed and its flags cleared
  task automatic fc(input logic [15:0] a, input logic [1:0] b, input logic h);
    tgt.fetch(a, b, 6'h15);
    repeat (3) @(posedge core_clk);
    check({31'h0, halt_req}, {31'h0, h}, "halt");
    if (h) begin
      wr(batb_pkg::CMD_OFS, 32'h8);
      wr(batb_pkg::STATUS_OFS, 32'h3);
      check({31'h0, halt_req}, 32'h0, "resume");
    end
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task stop_test;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    stop_test;
  end
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    failures = 0;
    compares = 0;
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    rc(batb_pkg::CTRL_OFS, 32'h0, "ctrl");
    rc(batb_pkg::QUAL_OFS, 32'h40000, "qual");
    rc(batb_pkg::STATUS_OFS, 32'h0, "status");
    rc(8'h30, 32'h0, "hole");
    done("reset");
    for (int v = 0; v < 2; v++) begin
      for (int m = 0; m < 4; m++) begin
        wr(batb_pkg::CTRL_OFS, 32'(v * 4 + m * 8));
        @(posedge core_clk);
        check({31'h0, xdata_emul_en}, 32'(v == 1 && m == 3), "xdata");
        if (v == 1) check({29'h0, bank_size_sel}, (m == 2) ? 32'h2 : 32'h1, "size");
      end
    end
    done("modes");
    wr(batb_pkg::CTRL_OFS, 32'h1);
    for (int b = 0; b < 4; b++) begin
      fc(16'h8000 + 16'(b), 2'(b), 1'b0);
      rc(batb_pkg::TRACE_OFS, {8'h0, 2'(b), 6'h15, 16'h8000 + 16'(b)}, "trace");
    end
    tgt.set_conn(1'b0, 1'b0);
    fc(16'h8010, 2'h3, 1'b0);
    rc(batb_pkg::TRACE_OFS, {8'h0, 2'h3, 6'h15, 16'h8010}, "open probe");
    tgt.set_conn(1'b1, 1'b1);
    rc(batb_pkg::STATUS_OFS, 32'h4, "flag");
    check({31'h0, irq}, 32'h0, "masked");
    wr(batb_pkg::IRQ_MASK_OFS, 32'h4);
    repeat (2) @(posedge core_clk);
    check({31'h0, irq}, 32'h1, "irq on");
    wr(batb_pkg::STATUS_OFS, 32'h4);
    repeat (2) @(posedge core_clk);
    check({31'h0, irq}, 32'h0, "irq off");
    wr(batb_pkg::IRQ_MASK_OFS, 32'h0);
    done("trace");
    wr(batb_pkg::CTRL_OFS, 32'h3);
    foreach (qt[i]) begin
      wr(batb_pkg::QUAL_OFS, qt[i][50:19]);
      fc(qt[i][18:3], qt[i][2:1], qt[i][0]);
    end
    done("qualifier");
    wr(batb_pkg::CTRL_OFS, 32'h21);
    wr(batb_pkg::CMD_OFS, 32'h1);
    idle;
    fc(16'h0123, 2'h0, 1'b1);
    fc(16'hffff, 2'h3, 1'b1);
    wr(batb_pkg::BPMEM_OFS, 32'h1234);
    wr(batb_pkg::CMD_OFS, 32'h2);
    idle;
    fc(16'h1234, 2'h0, 1'b0);
    fc(16'h1235, 2'h0, 1'b1);
    for (int i = 0; i < 4; i++) wr(batb_pkg::BRK_REG0_OFS + 8'(4 * i), 32'h8100 + 32'(i));
    wr(batb_pkg::CMD_OFS, 32'h4);
    idle;
    fc(16'h1235, 2'h0, 1'b0);
    fc(16'h8103, 2'h1, 1'b1);
    fc(16'h8100, 2'h1, 1'b1);
    fc(16'h8100, 2'h3, 1'b1);
    rc(batb_pkg::HALT_PC_OFS, 32'h8100, "halt pc");
    done("bpmem");
    stop_test;
  end
endmodule
